// File: reset_strap_capture_and_reg_attributes_bench.sv
// Self-checking bench for the strap capture and register attributes.
// Assumes the default attribute masks of the design.
`timescale 1ns/1ps
module reset_strap_capture_and_reg_attributes_bench;
    logic        clock_i = 1'b0, rst_b_i = 1'b0, cold = 1'b0, full = 1'b0;
    logic        cpu_n = 1'b0, wr = 1'b0, xor_o, allz, fhi;
    logic [3:0]  be = 4'h0, straps = 4'h0;
    logic [31:0] wd = 32'h0, hset = 32'h0, hval = 32'h5a, bus, rd;
    logic [6:0]  mhz;
    logic [2:0]  dep;
    logic [3:0]  tbl [4] = '{4'ha, 4'hf, 4'h0, 4'h5};
    int          error_cnt = 0, checks = 0;
    always #2.5 clock_i = ~clock_i;
    rsc_board board_u (.clock_i(clock_i), .cold_reset_i(cold), .processor_reset_n_i(cpu_n),
        .straps_i(straps), .bus_o(bus));
    rsc_strap_regs dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .cold_reset_i(cold),
        .full_reset_i(full), .processor_reset_n_i(cpu_n), .local_memory_data_bus_i(bus),
        .reg_write_i(wr), .reg_byte_en_i(be), .reg_wdata_i(wd), .hw_set_i(hset),
        .hw_value_i(hval), .xor_test_mode_o(xor_o), .all_outputs_z_o(allz),
        .host_freq_high_o(fhi), .host_freq_mhz_o(mhz), .in_order_queue_depth_o(dep),
        .reg_rdata_o(rd));
    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cold_boot(input logic [3:0] s);
        logic [31:0] e;
        e = {19'h0, s[3], 1'b0, s[1], s[1] ? rsc_pkg::HOST_MHZ_HIGH : rsc_pkg::HOST_MHZ_LOW,
             s[0] ? rsc_pkg::IOQ_DEPTH_SHALLOW : rsc_pkg::IOQ_DEPTH_DEEP};
        straps = s;
        cold = 1'b1;
        cpu_n = 1'b0;
        cyc(3);
        chk({31'h0, allz}, {31'h0, s[2]});
        cold = 1'b0;
        cyc(1);
        cpu_n = 1'b1;
        cyc(3);
        chk({19'h0, xor_o, allz, fhi, mhz, dep}, e);
        cpu_n = 1'b0;
        cyc(2);
        cpu_n = 1'b1;
        cyc(3);
        chk({19'h0, xor_o, allz, fhi, mhz, dep}, e);
    endtask : cold_boot
    // A write is taken at one edge and shows in the read data at that same edge.
    // Only the one defined register is written, with fixed patterns such as
    // all ones and all zeros, whatever its current contents are.
    task automatic wrc(input logic [3:0] b, input logic [31:0] d, input logic [27:0] e);
        be = b;
        wd = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
        chk(rd, {straps, e});
    endtask : wrc
    task automatic end_sim;
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    initial begin
        cyc(19);
        chk({19'h0, xor_o, allz, fhi, mhz, dep}, {22'h0, 7'h42, 3'h4});
        cyc(1);
        rst_b_i = 1'b1;
        cyc(2);
        chk(rd, 32'h0000_005a);
        foreach (tbl[i]) cold_boot(tbl[i]);
        wrc(4'hf, 32'hffff_ffff, 28'hfff_005a);
        wrc(4'hf, 32'h0000_0000, 28'h0ff_005a);
        hset = 32'h0000_ff00;
        cyc(1);
        hset = 32'h0;
        cyc(1);
        chk(rd, {straps, 28'h0ff_ff5a});
        wrc(4'hf, 32'h0000_0f00, 28'h0ff_f05a);
        wrc(4'h7, 32'hffff_ffff, 28'h0ff_005a);
        hset = 32'h0000_0f00;
        wrc(4'hf, 32'h0000_ff00, 28'h0ff_0f5a);
        hset = 32'h0;
        full = 1'b1;
        cyc(1);
        full = 1'b0;
        cyc(1);
        chk(rd, {straps, 28'h000_005a});
        wrc(4'hf, 32'h00ab_0000, 28'h000_005a);
        end_sim();
    end
endmodule : reset_strap_capture_and_reg_attributes_bench

// File: rsc_board.sv
// Board model: strap resistors on the memory data pins plus traffic.
// Assumes the bench holds straps_i steady while cold_reset_i is high.
`timescale 1ns/1ps
module rsc_board (
    input  wire logic        clock_i,
    input  wire logic        cold_reset_i,
    input  wire logic        processor_reset_n_i,
    input  wire logic [3:0]  straps_i,
    output logic      [31:0] bus_o
);
    logic [27:0] pat_q  = 28'h0;
    logic        boot_q = 1'b0;
    always_ff @(posedge clock_i) begin
        pat_q <= pat_q + 28'h1;
    end
    // The memory bus stays idle from cold reset until processor reset is
    // first released, so the resistors still set the pins at that edge.
    always_ff @(posedge clock_i) begin
        if (cold_reset_i) begin
            boot_q <= 1'b1;
        end else if (processor_reset_n_i) begin
            boot_q <= 1'b0;
        end
    end
    // Afterwards the pins carry traffic, so straps show inverted.
    // Bit 31 stays high so an XOR tree test is never cut short.
    assign bus_o = (cold_reset_i || boot_q) ? {straps_i, pat_q}
                                            : {1'b1, ~straps_i[2:0], ~pat_q};
endmodule : rsc_board

// File: rsc_pkg.sv
// Constants for the power-up strap capture and register attribute block.
// Assumes one 200 MHz clock domain and an active-low asynchronous reset.
package rsc_pkg;
    // ------------------------------------------------------------------
    // Strap bit positions on the local memory data bus
    // ------------------------------------------------------------------
    localparam int unsigned XOR_TEST_BIT  = 31;
    localparam int unsigned ALL_Z_BIT     = 30;
    localparam int unsigned HOST_FREQ_BIT = 29;
    localparam int unsigned IOQ_DEPTH_BIT = 28;

    // ------------------------------------------------------------------
    // Decoded values and reset defaults
    // ------------------------------------------------------------------
    localparam logic [2:0] IOQ_DEPTH_DEEP    = 3'h4;
    localparam logic [2:0] IOQ_DEPTH_SHALLOW = 3'h1;
    localparam logic [6:0] HOST_MHZ_LOW      = 7'h42;
    localparam logic [6:0] HOST_MHZ_HIGH     = 7'h64;
    localparam logic [3:0] STRAP_RESET_VALUE = 4'h0;
    localparam logic [31:0] CFG_RESET_VALUE  = 32'h0000_0000;
endpackage : rsc_pkg

// File: rsc_strap_regs.sv
// Strap capture during cold reset and a generic configuration register
// with per-bit read-only, write-one-to-clear and write-once attributes.
// Assumes all inputs are synchronous to clock_i.
`timescale 1ns/1ps

// How it works
// - A high strap on data bit 31 at cold reset enters XOR tree test mode, low is normal.
// - A high strap on data bit 30 at cold reset raises all_outputs_z_o to tri-state every output while cold reset lasts.
// - Data bit 29 at reset picks the host bus rate, low 66 MHz and high 100 MHz.
// - Data bit 28 at the rising edge of processor reset sets queue depth, low 4 and high 1.
// - Straps on bits 31 to 29 load only during cold reset; bit 28 loads at the first processor reset release after it.
// - Read-only bits ignore every software write.
// - Writing one to a write-one-to-clear bit clears it, zero leaves it, reads show it.
// - A write-once bit takes only the first write after power up, then is read-only.
// - Reserved locations may read back any value and may be 8, 16 or 32 bits wide.
// - Full reset returns the register to its default, some bits taken from the straps.
module rsc_strap_regs #(
    parameter int unsigned     WIDTH    = 32,
    parameter logic [31:0]     RO_MASK  = 32'h0000_00ff,
    parameter logic [31:0]     W1C_MASK = 32'h0000_ff00,
    parameter logic [31:0]     WO_MASK  = 32'h00ff_0000
) (
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire logic              cold_reset_i,
    input  wire logic              full_reset_i,
    input  wire logic              processor_reset_n_i,
    input  wire logic [31:0]       local_memory_data_bus_i,
    input  wire logic              reg_write_i,
    input  wire logic [3:0]        reg_byte_en_i,
    input  wire logic [WIDTH-1:0]  reg_wdata_i,
    input  wire logic [WIDTH-1:0]  hw_set_i,
    input  wire logic [WIDTH-1:0]  hw_value_i,
    output logic                   xor_test_mode_o,
    output logic                   all_outputs_z_o,
    output logic                   host_freq_high_o,
    output logic [6:0]             host_freq_mhz_o,
    output logic [2:0]             in_order_queue_depth_o,
    output logic [WIDTH-1:0]       reg_rdata_o
);
    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Straps are clocked in, bit 28 at processor reset release and the rest while
    // cold reset is held, never under the asynchronous reset, so no port value reaches a reset branch.
    logic [2:0] strap_q;
    logic       ioq_strap_q;
    logic       cpu_rst_n_q;
    logic       ioq_seen_q;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_q <= rsc_pkg::STRAP_RESET_VALUE[2:0];
        end else if (cold_reset_i) begin
            strap_q <= {local_memory_data_bus_i[rsc_pkg::XOR_TEST_BIT],
                        local_memory_data_bus_i[rsc_pkg::ALL_Z_BIT],
                        local_memory_data_bus_i[rsc_pkg::HOST_FREQ_BIT]};
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_rst_n_q <= 1'b0;
        end else begin
            cpu_rst_n_q <= processor_reset_n_i;
        end
    end

    // Only the first processor reset release after cold reset has ended
    // counts, so later warm resets cannot disturb the queue depth.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ioq_strap_q <= rsc_pkg::STRAP_RESET_VALUE[3];
            ioq_seen_q  <= 1'b0;
        end else if (cold_reset_i) begin
            ioq_seen_q <= 1'b0;
        end else if (processor_reset_n_i && !cpu_rst_n_q && !ioq_seen_q) begin
            ioq_strap_q <= local_memory_data_bus_i[rsc_pkg::IOQ_DEPTH_BIT];
            ioq_seen_q  <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xor_test_mode_o        <= 1'b0;
            all_outputs_z_o        <= 1'b0;
            host_freq_high_o       <= 1'b0;
            host_freq_mhz_o        <= rsc_pkg::HOST_MHZ_LOW;
            in_order_queue_depth_o <= rsc_pkg::IOQ_DEPTH_DEEP;
        end else begin
            xor_test_mode_o  <= strap_q[2];
            all_outputs_z_o  <= strap_q[1] && cold_reset_i;
            host_freq_high_o <= strap_q[0];
            host_freq_mhz_o  <= strap_q[0] ? rsc_pkg::HOST_MHZ_HIGH
                                           : rsc_pkg::HOST_MHZ_LOW;
            in_order_queue_depth_o <= ioq_strap_q ? rsc_pkg::IOQ_DEPTH_SHALLOW
                                                  : rsc_pkg::IOQ_DEPTH_DEEP;
        end
    end

    // ------------------------------------------------------------------
    // Attribute register
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] reg_q;
    logic [WIDTH-1:0] reg_d;
    logic [WIDTH-1:0] wo_done_q;
    logic [WIDTH-1:0] lane_mask;
    logic [WIDTH-1:0] rw_mask;

    always_comb begin
        lane_mask = '0;
        for (int i = 0; i < WIDTH; i++) begin
            lane_mask[i] = reg_byte_en_i[i / 8] && reg_write_i;
        end
    end

    assign rw_mask = ~(RO_MASK[WIDTH-1:0] | W1C_MASK[WIDTH-1:0] | WO_MASK[WIDTH-1:0]);

    always_comb begin
        reg_d = reg_q;
        reg_d = (reg_d & ~(rw_mask & lane_mask)) | (reg_wdata_i & rw_mask & lane_mask);
        reg_d = (reg_d & ~(WO_MASK[WIDTH-1:0] & lane_mask & ~wo_done_q))
              | (reg_wdata_i & WO_MASK[WIDTH-1:0] & lane_mask & ~wo_done_q);
        reg_d = reg_d & ~(W1C_MASK[WIDTH-1:0] & lane_mask & reg_wdata_i);
        // Hardware events win over a clear in the same cycle.
        reg_d = reg_d | (W1C_MASK[WIDTH-1:0] & hw_set_i);
        reg_d = (reg_d & ~RO_MASK[WIDTH-1:0]) | (hw_value_i & RO_MASK[WIDTH-1:0]);
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_q <= rsc_pkg::CFG_RESET_VALUE[WIDTH-1:0];
        end else if (full_reset_i) begin
            reg_q <= rsc_pkg::CFG_RESET_VALUE[WIDTH-1:0];
        end else begin
            reg_q <= reg_d;
        end
    end

    // Write-once history survives full reset; only power-up clears it.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wo_done_q <= '0;
        end else begin
            wo_done_q <= wo_done_q | (WO_MASK[WIDTH-1:0] & lane_mask);
        end
    end

    // Strap-derived status sits in the top bits of the read view. The block
    // holds no reserved locations, so every read returns defined data, which
    // the freedom given to reserved reads also allows.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= rsc_pkg::CFG_RESET_VALUE[WIDTH-1:0];
        end else begin
            reg_rdata_o <= {strap_q, ioq_strap_q, reg_d[WIDTH-5:0]};
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Pin values are compared two edges late, because the strap register and
    // the output register both sit between the pin and the port.
    sequence cold_release_s;
        cold_reset_i ##1 !cold_reset_i;
    endsequence

    sequence cold_held_s;
        cold_reset_i ##1 cold_reset_i;
    endsequence

    xor_mode_follows_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        cold_release_s |-> ##1 xor_test_mode_o == $past(local_memory_data_bus_i[31], 2))
        else $error("xor test mode does not match strap");
    all_z_only_reset_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        all_outputs_z_o |-> $past(cold_reset_i))
        else $error("tri-state outside reset");
    all_z_follows_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        cold_held_s |-> ##1 all_outputs_z_o
            == $past(local_memory_data_bus_i[rsc_pkg::ALL_Z_BIT], 2))
        else $error("tri-state does not follow strap during cold reset");
    freq_decode_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        host_freq_mhz_o == (host_freq_high_o ? 7'h64 : 7'h42))
        else $error("host frequency decode wrong");
    freq_pin_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        cold_release_s |-> ##1 host_freq_high_o
            == $past(local_memory_data_bus_i[rsc_pkg::HOST_FREQ_BIT], 2))
        else $error("host frequency does not match strap");
    ioq_sample_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!cold_reset_i && processor_reset_n_i && !cpu_rst_n_q && !ioq_seen_q)
        |-> ##2 in_order_queue_depth_o
            == ($past(local_memory_data_bus_i[28], 2) ? 3'h1 : 3'h4))
        else $error("queue depth not sampled at reset release");
    strap_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !cold_reset_i |=> $stable(strap_q))
        else $error("strap changed outside cold reset");
    ioq_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !(processor_reset_n_i && !cpu_rst_n_q && !ioq_seen_q) |=> $stable(ioq_strap_q))
        else $error("queue depth strap changed outside its sample edge");
    ro_ignore_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !full_reset_i |=> (reg_q & RO_MASK[WIDTH-1:0])
            == ($past(hw_value_i) & RO_MASK[WIDTH-1:0]))
        else $error("read-only bits took a write");
    w1c_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !full_reset_i |=> ((reg_q & W1C_MASK[WIDTH-1:0] & ~$past(hw_set_i))
        & ~$past(reg_q)) == '0)
        else $error("write-one-to-clear bit set by software");
    w1c_write_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        reg_write_i && !full_reset_i
        |=> (reg_q & W1C_MASK[WIDTH-1:0] & $past(reg_wdata_i & lane_mask & ~hw_set_i)) == '0)
        else $error("written one did not clear the bit");
    wo_lock_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !full_reset_i |=> ((reg_q ^ $past(reg_q)) & WO_MASK[WIDTH-1:0]
        & $past(wo_done_q)) == '0)
        else $error("write-once bit changed twice");
    wo_first_write_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        reg_write_i && !full_reset_i
        |=> ((reg_q ^ $past(reg_wdata_i)) & WO_MASK[WIDTH-1:0]
            & $past(lane_mask & ~wo_done_q)) == '0)
        else $error("first write to a write-once bit was lost");
    full_reset_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        full_reset_i |=> reg_q == rsc_pkg::CFG_RESET_VALUE[WIDTH-1:0])
        else $error("full reset did not restore default");
endmodule : rsc_strap_regs
